// >>> sew_ctrl_model.sv
// Two-wire bus controller model: drives the clock and pulls the data wire
`timescale 1ns/1ps
module sew_ctrl_model
#(
    parameter int Q_NS = 144
)
(
    // Bus
    output logic      serialClk,
    output logic      sdaPull,
    input  wire logic sdaWire
);
    initial
    begin
        serialClk = 1'b1;
        sdaPull   = 1'b0;
    end

    // Opens a command, also as a repeated start
    task automatic start();
        if (serialClk === 1'b0)
        begin
            #(Q_NS) sdaPull = 1'b0;
            #(Q_NS) serialClk = 1'b1;
        end
        #(Q_NS) sdaPull = 1'b1;
        #(Q_NS) serialClk = 1'b0;
    endtask : start

    // One bit, data moved while the clock is low
    task automatic clock_bit(input logic b, output logic seen);
        #(Q_NS) sdaPull = ~b;
        #(Q_NS) serialClk = 1'b1;
        #(Q_NS) seen = sdaWire;
        #(Q_NS) serialClk = 1'b0;
    endtask : clock_bit

    // Byte sent MSB first, wire released for the ninth clock
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(d[i], s);
        clock_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte

    // Closes a command; clock then stands high
    task automatic stop();
        #(Q_NS) sdaPull = 1'b1;
        #(Q_NS) serialClk = 1'b1;
        #(Q_NS) sdaPull = 1'b0;
        #(Q_NS);
    endtask : stop
endmodule : sew_ctrl_model

// >>> sew_mem.sv
// Byte array held in flip-flops with registered read port
`timescale 1ns/1ps
module sew_mem
#(
    parameter int ADDR_W = sew_pkg::ADDR_W,
    parameter int DATA_W = sew_pkg::DATA_W
)
(
    // System
    input  wire logic clk,
    input  wire logic rst_n,
    // Array port
    sew_mem_if.store  bus
);
    logic [DATA_W-1:0] cells_reg [2**ADDR_W];
    logic [DATA_W-1:0] rdData_reg;

    always_ff @(posedge clk)
    begin
        if (bus.wrEn)
        begin
            cells_reg[bus.wrAddr] <= bus.wrData;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdData_reg <= '0;
        end
        else
        begin
            rdData_reg <= cells_reg[bus.rdAddr];
        end
    end

    assign bus.rdData = rdData_reg;
endmodule : sew_mem

// >>> sew_mem_if.sv
// Write and read port bundle between the engine and the array
`timescale 1ns/1ps
interface sew_mem_if
#(
    parameter int ADDR_W = sew_pkg::ADDR_W,
    parameter int DATA_W = sew_pkg::DATA_W
);
    logic              wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic [ADDR_W-1:0] rdAddr;
    logic [DATA_W-1:0] rdData;
    modport ctrl  (output wrEn, wrAddr, wrData, rdAddr, input rdData);
    modport store (input wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface : sew_mem_if

// >>> sew_pkg.sv
// Shared constants for the serial EEPROM byte write target
package sew_pkg;
    localparam int         ADDR_W        = 14;
    localparam int         DATA_W        = 8;
    localparam int         PAGE_COUNT    = 256;
    localparam int         PAGE_BYTES    = 64;
    localparam int         OFFSET_W      = 6;
    localparam int         PAGE_W        = 8;
    localparam int         HI_USED_W     = 6;
    localparam int         LO_PAGE_W     = 2;
    localparam logic [3:0] BIT_LAST      = 4'h7;
    localparam logic [3:0] BIT_ACK       = 4'h8;
    localparam logic [3:0] DEV_PREFIX    = 4'ha;
    localparam int         PREFIX_LSB    = 4;
    localparam int         SEL_LSB       = 1;
    localparam int         RW_BIT        = 0;
    localparam int         SYNC_W        = 7;
    localparam int         CLK_HZ        = 40000000;
    localparam int         WRITE_TIME_MS = 5;
    localparam int         WRITE_CYCLES  = WRITE_TIME_MS * (CLK_HZ / 1000);
endpackage : sew_pkg

// >>> sew_sync.sv
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
module sew_sync
#(
    parameter int WIDTH = 1
)
(
    // System
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end
        else
        begin
            stage1_reg <= din;
            stage2_reg <= stage1_reg;
        end
    end

    assign dout = stage2_reg;
endmodule : sew_sync

// >>> sew_top.sv
// Serial EEPROM target: addressing, byte and page write, timed cycle
`timescale 1ns/1ps
module sew_top
#(
    parameter int WRITE_CYCLES = sew_pkg::WRITE_CYCLES
)
(
    // System
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Serial link
    input  wire logic                        serialClk,
    input  wire logic                        sdaIn,
    output logic                             sdaOut,
    output logic                             sdaOe,
    // Straps
    input  wire logic                        selectAddrBit2,
    input  wire logic                        selectAddrBit1,
    input  wire logic                        selectAddrBit0,
    input  wire logic                        writeProtect,
    // Array read port
    input  wire logic [sew_pkg::ADDR_W-1:0]  memRdAddr,
    output logic      [sew_pkg::DATA_W-1:0]  memRdData,
    // Status
    output logic                             progBusy
);
    localparam int TIMER_W = $clog2(WRITE_CYCLES + 1);

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_DEVADDR,
        ST_ADDRHI,
        ST_ADDRLO,
        ST_DATA,
        ST_READ,
        ST_PROG
    } sew_state_t;

    sew_state_t                       state_reg;
    logic [7:0]                       shiftReg_reg;
    logic                             bitToggle_reg;
    logic [sew_pkg::SYNC_W-1:0]       syncOut;
    logic                             sclS;
    logic                             sdaS;
    logic [2:0]                       selS;
    logic                             wpS;
    logic                             toggleS;
    logic                             sclPrev_reg;
    logic                             sdaPrev_reg;
    logic                             togglePrev_reg;
    logic                             startEv;
    logic                             stopEv;
    logic                             sclFall;
    logic                             riseEv;
    logic                             byteDone;
    logic                             ackWanted;
    logic                             ackPend_reg;
    logic                             sdaOe_reg;
    logic [3:0]                       bitCnt_reg;
    logic [sew_pkg::PAGE_W-1:0]       pageReg_reg;
    logic [sew_pkg::OFFSET_W-1:0]     offset_reg;
    logic [sew_pkg::DATA_W-1:0]       pageBuf_reg [sew_pkg::PAGE_BYTES];
    logic [sew_pkg::PAGE_BYTES-1:0]   validMask_reg;
    logic [TIMER_W-1:0]               progTimer_reg;
    logic                             progDone;
    logic                             commitReq;
    logic [sew_pkg::OFFSET_W-1:0]     commitIdx;

    function automatic logic isOurAddress(input logic [7:0] word,
                                          input logic [2:0] sel);
        return (word[sew_pkg::PREFIX_LSB +: 4] == sew_pkg::DEV_PREFIX) &&
               (word[sew_pkg::SEL_LSB +: 3] == sel);
    endfunction : isOurAddress

    // Link clock domain: bit capture and per-bit event toggle
    always_ff @(posedge serialClk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shiftReg_reg  <= 8'h00;
            bitToggle_reg <= 1'b0;
        end
        else
        begin
            shiftReg_reg  <= {shiftReg_reg[6:0], sdaIn};
            bitToggle_reg <= ~bitToggle_reg;
        end
    end

    // Pins and link toggle into the system clock domain
    sew_sync #(
        .WIDTH (sew_pkg::SYNC_W)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({serialClk, sdaIn, selectAddrBit2, selectAddrBit1,
                 selectAddrBit0, writeProtect, bitToggle_reg}),
        .dout  (syncOut)
    );

    assign sclS    = syncOut[6];
    assign sdaS    = syncOut[5];
    assign selS    = syncOut[4:2];
    assign wpS     = syncOut[1];
    assign toggleS = syncOut[0];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclPrev_reg    <= 1'b0;
            sdaPrev_reg    <= 1'b0;
            togglePrev_reg <= 1'b0;
        end
        else
        begin
            sclPrev_reg    <= sclS;
            sdaPrev_reg    <= sdaS;
            togglePrev_reg <= toggleS;
        end
    end

    // Bus conditions
    assign startEv = sclS && sclPrev_reg && sdaPrev_reg && !sdaS;
    assign stopEv  = sclS && sclPrev_reg && !sdaPrev_reg && sdaS;
    assign sclFall = sclPrev_reg && !sclS;
    assign riseEv  = toggleS != togglePrev_reg;

    // Byte framing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bitCnt_reg <= 4'h0;
        end
        else if (state_reg == ST_PROG || startEv)
        begin
            bitCnt_reg <= 4'h0;
        end
        else if (riseEv)
        begin
            bitCnt_reg <= (bitCnt_reg == sew_pkg::BIT_ACK) ? 4'h0
                          : bitCnt_reg + 4'h1;
        end
    end

    assign byteDone = riseEv && !startEv &&
                      bitCnt_reg == sew_pkg::BIT_LAST &&
                      state_reg != ST_IDLE && state_reg != ST_PROG;

    // Acknowledge decision
    always_comb
    begin
        ackWanted = 1'b0;
        case (state_reg)
            ST_DEVADDR:
            begin
                ackWanted = isOurAddress(shiftReg_reg, selS);
            end
            ST_ADDRHI, ST_ADDRLO, ST_DATA:
            begin
                ackWanted = 1'b1;
            end
            default:
            begin
                ackWanted = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ackPend_reg <= 1'b0;
        end
        else if (state_reg == ST_PROG || startEv || stopEv)
        begin
            ackPend_reg <= 1'b0;
        end
        else if (byteDone)
        begin
            ackPend_reg <= ackWanted;
        end
        else if (riseEv && bitCnt_reg == sew_pkg::BIT_ACK)
        begin
            ackPend_reg <= 1'b0;
        end
    end

    // Open-drain drive, set only after a clock fall; also cleared on start, stop or programming
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sdaOe_reg <= 1'b0;
        end
        else if (state_reg == ST_PROG || startEv || stopEv)
        begin
            sdaOe_reg <= 1'b0;
        end
        else if (sclFall)
        begin
            sdaOe_reg <= ackPend_reg &&
                         bitCnt_reg == sew_pkg::BIT_ACK;
        end
    end

    assign sdaOe  = sdaOe_reg;
    assign sdaOut = 1'b0;

    // Command sequencing
    assign commitReq = state_reg == ST_DATA && (|validMask_reg) && !wpS;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
        end
        else if (state_reg == ST_PROG)
        begin
            if (progDone)
            begin
                state_reg <= ST_IDLE;
            end
        end
        else if (startEv)
        begin
            state_reg <= ST_DEVADDR;
        end
        else if (stopEv)
        begin
            state_reg <= commitReq ? ST_PROG : ST_IDLE;
        end
        else if (byteDone)
        begin
            case (state_reg)
                ST_DEVADDR:
                begin
                    if (!isOurAddress(shiftReg_reg, selS))
                    begin
                        state_reg <= ST_IDLE;
                    end
                    else if (shiftReg_reg[sew_pkg::RW_BIT])
                    begin
                        state_reg <= ST_READ;
                    end
                    else
                    begin
                        state_reg <= ST_ADDRHI;
                    end
                end
                ST_ADDRHI:
                begin
                    state_reg <= ST_ADDRLO;
                end
                ST_ADDRLO:
                begin
                    state_reg <= ST_DATA;
                end
                default:
                begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // Byte address capture and page offset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pageReg_reg <= '0;
            offset_reg  <= '0;
        end
        else if (byteDone)
        begin
            case (state_reg)
                ST_ADDRHI:
                begin
                    pageReg_reg[sew_pkg::PAGE_W-1 -: sew_pkg::HI_USED_W]
                        <= shiftReg_reg[sew_pkg::HI_USED_W-1:0];
                end
                ST_ADDRLO:
                begin
                    pageReg_reg[sew_pkg::LO_PAGE_W-1:0]
                        <= shiftReg_reg[7 -: sew_pkg::LO_PAGE_W];
                    offset_reg <= shiftReg_reg[sew_pkg::OFFSET_W-1:0];
                end
                ST_DATA:
                begin
                    offset_reg <= offset_reg + 6'h01;
                end
                default:
                begin
                    offset_reg <= offset_reg;
                end
            endcase
        end
    end

    // Page latch
    always_ff @(posedge clk)
    begin
        if (byteDone && state_reg == ST_DATA)
        begin
            pageBuf_reg[offset_reg] <= shiftReg_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            validMask_reg <= '0;
        end
        else if (progDone || (startEv && state_reg != ST_PROG))
        begin
            validMask_reg <= '0;
        end
        else if (byteDone && state_reg == ST_DATA)
        begin
            validMask_reg[offset_reg] <= 1'b1;
        end
    end

    // Self-timed programming cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            progTimer_reg <= '0;
        end
        else if (state_reg == ST_PROG)
        begin
            progTimer_reg <= progTimer_reg + TIMER_W'(1);
        end
        else
        begin
            progTimer_reg <= '0;
        end
    end

    assign progDone  = state_reg == ST_PROG &&
                       progTimer_reg == TIMER_W'(WRITE_CYCLES - 1);
    assign commitIdx = progTimer_reg[sew_pkg::OFFSET_W-1:0];
    assign progBusy  = state_reg == ST_PROG;

    // Array
    sew_mem_if memBus ();

    assign memBus.wrEn   = state_reg == ST_PROG &&
                           progTimer_reg < TIMER_W'(sew_pkg::PAGE_BYTES) &&
                           validMask_reg[commitIdx];
    assign memBus.wrAddr = {pageReg_reg, commitIdx};
    assign memBus.wrData = pageBuf_reg[commitIdx];
    assign memBus.rdAddr = memRdAddr;
    assign memRdData     = memBus.rdData;

    sew_mem u_mem (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (memBus)
    );

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_OPEN_DRAIN: assert property (
        $rose(sdaOe) |-> $past(ackPend_reg) && sdaOut == 1'b0)
        else $error("data line driven without a pending acknowledge");
    AST_ACK_WINDOW: assert property (
        sdaOe |-> bitCnt_reg == sew_pkg::BIT_ACK || bitCnt_reg == 4'h0)
        else $error("acknowledge outside the ninth clock");
    AST_DEV_PREFIX: assert property (
        byteDone && state_reg == ST_DEVADDR &&
        shiftReg_reg[7:4] != sew_pkg::DEV_PREFIX
        |=> state_reg == ST_IDLE && !ackPend_reg)
        else $error("wrong prefix not rejected");
    AST_SELECT_MISMATCH: assert property (
        byteDone && state_reg == ST_DEVADDR && shiftReg_reg[3:1] != selS
        |=> state_reg == ST_IDLE)
        else $error("select mismatch did not return to standby");
    AST_RW_DIR: assert property (
        byteDone && state_reg == ST_DEVADDR &&
        isOurAddress(shiftReg_reg, selS)
        |=> (state_reg == ST_READ) == $past(shiftReg_reg[0]))
        else $error("direction bit decoded wrongly");
    AST_START: assert property (
        startEv && state_reg != ST_PROG
        |=> state_reg == ST_DEVADDR && bitCnt_reg == 4'h0)
        else $error("start not recognised");
    AST_READ_STOP: assert property (
        stopEv && state_reg == ST_READ |=> state_reg == ST_IDLE)
        else $error("stop after read did not give standby");
    AST_WP_BLOCK: assert property (
        stopEv && state_reg == ST_DATA && wpS |=> state_reg == ST_IDLE)
        else $error("programming started while protected");
    AST_PROG_SILENT: assert property (
        state_reg == ST_PROG |-> !sdaOe && !ackPend_reg)
        else $error("answer given during programming");
    AST_PROG_TIME: assert property (
        state_reg == ST_PROG |-> progTimer_reg < TIMER_W'(WRITE_CYCLES))
        else $error("programming ran past its time");
    AST_PAGE_WRAP: assert property (
        byteDone && state_reg == ST_DATA
        |=> offset_reg == $past(offset_reg) + 6'h01 && $stable(pageReg_reg))
        else $error("page offset did not advance within the page");
    AST_COMMIT_ON_STOP: assert property (
        $rose(state_reg == ST_PROG) |-> $past(stopEv))
        else $error("programming began without a stop");
    AST_HI_IGNORED: assert property (
        byteDone && state_reg == ST_ADDRHI
        |=> pageReg_reg[7:2] == $past(shiftReg_reg[5:0]))
        else $error("high address byte captured wrongly");

    COV_BYTE_WRITE: cover property ($rose(state_reg == ST_PROG));
    COV_READ_ACK: cover property (state_reg == ST_READ && sdaOe);
    COV_MISMATCH: cover property (
        byteDone && state_reg == ST_DEVADDR &&
        !isOurAddress(shiftReg_reg, selS));
    COV_WRAP: cover property (
        byteDone && state_reg == ST_DATA && offset_reg == 6'h3f);
endmodule : sew_top

// >>> tb_sew_top.sv
// Testbench for the serial EEPROM byte write target
`timescale 1ns/1ps
module tb_sew_top;
    localparam int WCYC = 2000;
    logic        clk;
    logic        rst_n;
    logic        serialClk;
    logic        sdaPull;
    logic        sdaWire;
    logic        sdaOut;
    logic        sdaOe;
    logic        writeProtect;
    logic        progBusy;
    logic [2:0]  sel;
    logic [13:0] memRdAddr;
    logic [7:0]  memRdData;
    int          errors = 0;
    int          compares = 0;

    // Wired level with pull-up
    assign sdaWire = !(sdaPull || (sdaOe && !sdaOut));

    sew_top #(.WRITE_CYCLES(WCYC)) u_dut
    (
        .clk,
        .rst_n,
        .serialClk,
        .sdaIn          (sdaWire),
        .sdaOut,
        .sdaOe,
        .selectAddrBit2 (sel[2]),
        .selectAddrBit1 (sel[1]),
        .selectAddrBit0 (sel[0]),
        .writeProtect,
        .memRdAddr,
        .memRdData,
        .progBusy
    );

    sew_ctrl_model u_ctrl
    (
        .serialClk,
        .sdaPull,
        .sdaWire
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic close_out();
        $display("Counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %0t %s: %h not %h", $time, what, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] dev(input logic rw);
        return {sew_pkg::DEV_PREFIX, sel, rw};
    endfunction : dev

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask : settle

    task automatic word(input logic [7:0] d, input logic exp);
        logic a;
        u_ctrl.send_byte(d, a);
        check(8'(a), 8'(exp), "acknowledge");
        check(8'(sdaOut), 8'h00, "drive level");
    endtask : word

    task automatic rd_mem(input logic [13:0] a, input logic [7:0] exp);
        @(negedge clk);
        memRdAddr = a;
        @(negedge clk);
        check(memRdData, exp, "array byte");
    endtask : rd_mem

    task automatic wait_idle();
        int n;
        n = 0;
        while (progBusy !== 1'b0 && n < WCYC + 8)
        begin
            @(negedge clk);
            n++;
        end
        check(8'(progBusy), 8'h00, "cycle end");
    endtask : wait_idle

    task automatic t_byte_write();
        @(negedge clk);
        sel = 3'h5;
        u_ctrl.start();
        word(dev(1'b0), 1'b1);
        word(8'hff, 1'b1);
        word(8'h41, 1'b1);
        word(8'h5a, 1'b1);
        u_ctrl.stop();
        settle(4);
        check(8'(progBusy), 8'h01, "cycle start");
        u_ctrl.start();
        word(dev(1'b0), 1'b0);
        u_ctrl.stop();
        check(8'(progBusy), 8'h01, "still busy");
        wait_idle();
        u_ctrl.start();
        word(dev(1'b1), 1'b1);
        u_ctrl.stop();
        settle(8);
        check(8'(progBusy), 8'h00, "read standby");
        rd_mem(14'h3f41, 8'h5a);
        $display("t_byte_write done");
    endtask : t_byte_write

    task automatic t_mismatch();
        @(negedge clk);
        sel = 3'h3;
        u_ctrl.start();
        word({4'hb, sel, 1'b0}, 1'b0);
        u_ctrl.start();
        word({sew_pkg::DEV_PREFIX, 3'h2, 1'b0}, 1'b0);
        word(8'h00, 1'b0);
        u_ctrl.stop();
        settle(8);
        check(8'(progBusy), 8'h00, "no cycle");
        $display("t_mismatch done");
    endtask : t_mismatch

    task automatic t_page_wrap();
        @(negedge clk);
        sel = 3'h0;
        u_ctrl.start();
        word(dev(1'b0), 1'b1);
        word(8'h02, 1'b1);
        word(8'hbe, 1'b1);
        for (int i = 1; i <= 4; i++)
            word(8'(i * 8'h11), 1'b1);
        u_ctrl.stop();
        wait_idle();
        rd_mem(14'h02be, 8'h11);
        rd_mem(14'h02bf, 8'h22);
        rd_mem(14'h0280, 8'h33);
        rd_mem(14'h0281, 8'h44);
        $display("t_page_wrap done");
    endtask : t_page_wrap

    task automatic t_protect_abort();
        @(negedge clk);
        writeProtect = 1'b1;
        u_ctrl.start();
        word(dev(1'b0), 1'b1);
        word(8'h02, 1'b1);
        word(8'h80, 1'b1);
        word(8'hee, 1'b1);
        u_ctrl.stop();
        settle(8);
        check(8'(progBusy), 8'h00, "protected");
        u_ctrl.start();
        word(dev(1'b1), 1'b1);
        u_ctrl.stop();
        @(negedge clk);
        writeProtect = 1'b0;
        u_ctrl.start();
        word(dev(1'b0), 1'b1);
        word(8'h02, 1'b1);
        word(8'h81, 1'b1);
        word(8'hdd, 1'b1);
        u_ctrl.start();
        u_ctrl.stop();
        settle(8);
        check(8'(progBusy), 8'h00, "aborted");
        rd_mem(14'h0280, 8'h33);
        rd_mem(14'h0281, 8'h44);
        $display("t_protect_abort done");
    endtask : t_protect_abort

    initial
    begin
        #(40000 * 25);
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        close_out();
    end

    initial
    begin
        rst_n = 1'b1;
        sel = 3'h0;
        writeProtect = 1'b0;
        memRdAddr = 14'h0000;
        #1;
        rst_n = 1'b0; // Asserted after time zero so every flop with an asynchronous reset sees it
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        settle(4);
        check(8'(sdaOe), 8'h00, "idle drive");
        check(8'(progBusy), 8'h00, "idle busy");
        t_byte_write();
        t_mismatch();
        t_page_wrap();
        t_protect_abort();
        close_out();
    end
endmodule : tb_sew_top
